// File: pkg/pcm_defs.vh
`ifndef PCM_DEFS_VH
`define PCM_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CLOCK 8'h04
`define OFS_ROUTE 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RXDATA 8'h10

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define CTRL_RST 32'h0000_0080
`define CLOCK_RST 32'h0000_4033
`define ROUTE_RST 32'h0000_0000
`define CTRL_MASK 32'h0000_07ff
`define CLOCK_MASK 32'h0003_ffff
`define ROUTE_MASK 32'h0000_07ff
`define ZERO32 32'h0000_0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_FMT 3:1
`define CTRL_WS 5:4
`define CTRL_CL 7:6
`define CTRL_EDGE 8
`define CTRL_POL 9
`define CTRL_HIZ 10
`define CLK_SR 3:0
`define CLK_SENSE 7:4
`define CLK_RATIO 17:8
`define ROUTE_CH 3:0
`define ROUTE_SLOT 10:4
`define ST_RATIO 4:0
`define ST_CHANS 9:5
`define ST_SLOTS 17:10
`define ST_RUN 18

// ----------------------------------------
// formats, lengths, delays
// ----------------------------------------
`define FMT_I2S 3'h0
`define FMT_LJ 3'h1
`define FMT_TDM0 3'h2
`define FMT_TDM1 3'h3
`define FMT_TDM2 3'h4
`define LEN_16 2'h0
`define LEN_24 2'h1
`define LEN_32 2'h2
`define BITS_16 6'h10
`define BITS_24 6'h18
`define BITS_32 6'h20
`define DLY_0 2'h0
`define DLY_1 2'h1
`define DLY_2 2'h2
`define CH_LEFT 5'h0
`define CH_RIGHT 5'h1
`define MAX_CH 5'h10
`define MAX_SLOTS 8'h80
`define SLOT_W 3
`define POS_MAX 10'h3ff

// ----------------------------------------
// sample rates in units of 25 hz
// ----------------------------------------
`define RATE_192 13'h1e00
`define RATE_96 13'h0f00
`define RATE_882 13'h0dc8
`define RATE_48 13'h0780
`define RATE_441 13'h06e4
`define RATE_32 13'h0500
`define RATE_24 13'h03c0
`define RATE_2205 13'h0372
`define RATE_16 13'h0280
`define RATE_12 13'h01e0
`define RATE_11025 13'h01b9
`define RATE_8 13'h0140

`endif

// File: rtl/pcm_apb_regs.v
`timescale 1ns/1ps
`include "pcm_defs.vh"

module pcm_apb_regs (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // configuration out
    output wire [31:0] ctrl,
    output wire [31:0] clock,
    output wire [31:0] route,
    // state in
    input wire [31:0] status,
    input wire [31:0] rxdata
);

reg [31:0] ctrl_reg;
reg [31:0] clock_reg;
reg [31:0] route_reg;
reg [31:0] prdata_reg;
reg pready_reg;
reg pslverr_reg;
reg [31:0] rd_next;
reg hit_next;

wire setup = psel & ~penable;
wire wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;

assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;
assign ctrl = ctrl_reg;
assign clock = clock_reg;
assign route = route_reg;

// ----------------------------------------
// read decode
// ----------------------------------------
always @* begin
    rd_next = `ZERO32;
    hit_next = 1'b1;
    case (paddr)
        `OFS_CTRL: rd_next = ctrl_reg;
        `OFS_CLOCK: rd_next = clock_reg;
        `OFS_ROUTE: rd_next = route_reg;
        `OFS_STATUS: rd_next = status;
        `OFS_RXDATA: rd_next = rxdata;
        default: hit_next = 1'b0;
    endcase
end

// ----------------------------------------
// bus phases and writes
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `CTRL_RST;
        clock_reg <= `CLOCK_RST;
        route_reg <= `ROUTE_RST;
        prdata_reg <= `ZERO32;
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
    end else begin
        pready_reg <= setup;
        pslverr_reg <= setup & ~hit_next;
        if (setup) begin
            prdata_reg <= pwrite ? `ZERO32 : rd_next;
        end
        if (wr_en) begin
            case (paddr)
                `OFS_CTRL: ctrl_reg <= pwdata & `CTRL_MASK;
                `OFS_CLOCK: clock_reg <= pwdata & `CLOCK_MASK;
                `OFS_ROUTE: route_reg <= pwdata & `ROUTE_MASK;
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end
end

endmodule

// File: rtl/pcm_sense_repeat.v
`timescale 1ns/1ps
`include "pcm_defs.vh"

module pcm_sense_repeat (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // frame timing and rates
    input wire frame,
    input wire [3:0] sr_code,
    input wire [3:0] sense_code,
    // sample in and out
    input wire [31:0] sense_data,
    output wire [31:0] held,
    output wire take,
    output wire [4:0] ratio
);

reg [31:0] held_reg;
reg take_reg;
reg [4:0] cnt_reg;

function [12:0] rate_val;
    input [3:0] code;
    begin
        case (code)
            4'h0: rate_val = `RATE_192;
            4'h1: rate_val = `RATE_96;
            4'h2: rate_val = `RATE_882;
            4'h3: rate_val = `RATE_48;
            4'h4: rate_val = `RATE_441;
            4'h5: rate_val = `RATE_32;
            4'h6: rate_val = `RATE_24;
            4'h7: rate_val = `RATE_2205;
            4'h8: rate_val = `RATE_16;
            4'h9: rate_val = `RATE_12;
            4'ha: rate_val = `RATE_11025;
            default: rate_val = `RATE_8;
        endcase
    end
endfunction

wire [12:0] quot = rate_val(sr_code) / rate_val(sense_code);
wire [4:0] cnt_inc = cnt_reg + 5'h1;
wire load = frame & (cnt_reg == 5'h0);

assign ratio = quot[4:0];
// new sample already visible at the frame start edge
assign held = load ? sense_data : held_reg;
assign take = take_reg;

// ----------------------------------------
// hold each sample for ratio frames
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        held_reg <= `ZERO32;
        take_reg <= 1'b0;
        cnt_reg <= 5'h0;
    end else begin
        take_reg <= load;
        if (frame) begin
            if (load) begin
                held_reg <= sense_data;
            end
            cnt_reg <= (cnt_inc >= ratio) ? 5'h0 : cnt_inc;
        end
    end
end

endmodule

// File: rtl/pcm_target_if.v
`timescale 1ns/1ps
// Behaviour
// - playback runs at interface frame rate
// - repeat sense sample over rate ratio
// - format field picks i2s, lj, tdm
// - drop extra rx bits, pad tx bits
// - falling frame clock starts channel 0
// - i2s msb on second active edge
// - lj msb on first active edge
// - control bit picks active bit edge
// - polarity bit picks channel 0 edge
// - output changes on the active edge
// - tdm takes up to 16 channels
// - tdm output in 8-bit slots, 128 max
// - channels and slots from clock ratio
// - tdm rising frame clock is sync
// - tdm msb on edge 1, 2, 3
`include "pcm_defs.vh"

module pcm_target_if (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // pcm pins
    input wire bclk,
    input wire lrclk,
    input wire din,
    output wire dout,
    output wire dout_oe,
    // playback path
    output wire [31:0] spk_data,
    output wire spk_valid,
    // sense path
    input wire [31:0] sense_data,
    output wire sense_take
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [5:0] len_bits;
    input [1:0] code;
    begin
        case (code)
            `LEN_16: len_bits = `BITS_16;
            `LEN_24: len_bits = `BITS_24;
            default: len_bits = `BITS_32;
        endcase
    end
endfunction

function [1:0] msb_ofs;
    input [2:0] fmt;
    begin
        case (fmt)
            `FMT_I2S: msb_ofs = `DLY_1;
            `FMT_TDM1: msb_ofs = `DLY_1;
            `FMT_TDM2: msb_ofs = `DLY_2;
            default: msb_ofs = `DLY_0;
        endcase
    end
endfunction

function [31:0] align_word;
    input [31:0] w;
    input [5:0] ws;
    begin
        case (ws)
            `BITS_16: align_word = {w[15:0], 16'h0000};
            `BITS_24: align_word = {w[23:0], 8'h00};
            default: align_word = w;
        endcase
    end
endfunction

// ----------------------------------------
// configuration
// ----------------------------------------
wire [31:0] ctrl;
wire [31:0] clock;
wire [31:0] route;
wire [31:0] status;
wire [31:0] held;
wire [4:0] rep_ratio;

wire en = ctrl[`CTRL_EN];
wire [2:0] fmt = ctrl[`CTRL_FMT];
wire edge_sel = ctrl[`CTRL_EDGE];
wire pol = ctrl[`CTRL_POL];
wire hiz = ctrl[`CTRL_HIZ];
wire [5:0] ws = len_bits(ctrl[`CTRL_WS]);
wire [5:0] cl = len_bits(ctrl[`CTRL_CL]);
wire [9:0] ratio = clock[`CLK_RATIO];
wire tdm = fmt >= `FMT_TDM0;
wire [1:0] ofs = msb_ofs(fmt);

// available channels and slots
wire [9:0] ch_q = ratio / {4'h0, cl};
wire [9:0] slot_q = ratio >> `SLOT_W;
wire [4:0] chans = (ch_q > {5'h00, `MAX_CH}) ? `MAX_CH : ch_q[4:0];
wire [7:0] slots = (slot_q > {2'h0, `MAX_SLOTS}) ? `MAX_SLOTS : slot_q[7:0];

// ----------------------------------------
// bit clock and frame clock tracking
// ----------------------------------------
reg bclk_reg;
reg lr_reg;
reg run_reg;
reg [1:0] skip_reg;
reg [4:0] ch_reg;
reg [5:0] bit_reg;
reg [9:0] pos_reg;

// only the host bit clock times the frame
wire rise = bclk & ~bclk_reg;
wire fall = ~bclk & bclk_reg;
wire act_raw = edge_sel ? rise : fall;
wire act = act_raw & en;
wire trans = act & (lrclk != lr_reg);
// i2s/lj: level equal to polarity starts channel 0; tdm: the opposite edge
wire fstart = trans & (tdm ? (lrclk != pol) : (lrclk == pol));
wire restart = tdm ? fstart : trans;
wire [4:0] new_ch = (tdm | (lrclk == pol)) ? `CH_LEFT : `CH_RIGHT;
wire use_new = restart & (ofs == `DLY_0);

// context of the bit handled at this edge
wire [4:0] d_ch = use_new ? new_ch : ch_reg;
wire [5:0] d_bit = use_new ? 6'h00 : bit_reg;
wire [9:0] d_pos = use_new ? 10'h000 : pos_reg;
wire d_go = act & (use_new ? (run_reg | fstart) : (run_reg & (skip_reg == `DLY_0)));

// advance to the next bit position
wire last_bit = d_bit == (cl - 6'h01);
wire [5:0] adv_bit = last_bit ? 6'h00 : d_bit + 6'h01;
wire [4:0] adv_ch = (last_bit & (d_ch != `MAX_CH)) ? d_ch + 5'h01 : d_ch;
wire [9:0] adv_pos = (d_pos == `POS_MAX) ? d_pos : d_pos + 10'h001;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bclk_reg <= 1'b0;
        lr_reg <= 1'b0;
        run_reg <= 1'b0;
        skip_reg <= `DLY_0;
        ch_reg <= `CH_LEFT;
        bit_reg <= 6'h00;
        pos_reg <= 10'h000;
    end else begin
        bclk_reg <= bclk;
        if (act_raw) begin
            lr_reg <= lrclk;
        end
        if (!en) begin
            run_reg <= 1'b0;
            skip_reg <= `DLY_0;
            ch_reg <= `CH_LEFT;
            bit_reg <= 6'h00;
            pos_reg <= 10'h000;
        end else if (act) begin
            if (fstart) begin
                run_reg <= 1'b1;
            end
            if (restart & ~use_new) begin
                // delayed formats skip edges before the msb
                ch_reg <= new_ch;
                bit_reg <= 6'h00;
                pos_reg <= 10'h000;
                skip_reg <= ofs - `DLY_1;
            end else if (d_go) begin
                ch_reg <= adv_ch;
                bit_reg <= adv_bit;
                pos_reg <= adv_pos;
            end else if (skip_reg != `DLY_0) begin
                skip_reg <= skip_reg - `DLY_1;
            end
        end
    end
end

// ----------------------------------------
// receive path
// ----------------------------------------
reg [31:0] sh_reg;
reg [31:0] spk_data_reg;
reg spk_valid_reg;

wire rx_bit = d_go & (d_bit < ws) & (d_ch < `MAX_CH);
wire rx_done = rx_bit & (d_bit == (ws - 6'h01));
wire [31:0] rx_word = {sh_reg[30:0], din};
wire play_hit = rx_done & (d_ch == {1'b0, route[`ROUTE_CH]});

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sh_reg <= `ZERO32;
        spk_data_reg <= `ZERO32;
        spk_valid_reg <= 1'b0;
    end else begin
        if (rx_bit) begin
            sh_reg <= rx_word;
        end
        // one playback word per frame at the interface rate
        spk_valid_reg <= play_hit;
        if (play_hit) begin
            spk_data_reg <= align_word(rx_word, ws);
        end
    end
end

// ----------------------------------------
// transmit path
// ----------------------------------------
reg dout_reg;
reg dout_oe_reg;

wire [9:0] slot_base = {3'h0, route[`ROUTE_SLOT]} << `SLOT_W;
wire [9:0] rel = d_pos - slot_base;
wire [9:0] d_slot = d_pos >> `SLOT_W;
wire in_range = ~tdm | (d_slot < {2'h0, slots});
wire after_base = d_pos >= slot_base;
wire t_word = tdm ? (after_base & (rel < {4'h0, ws})) : (d_bit < ws);
wire t_pad = tdm ? (after_base & (rel < {4'h0, cl})) : (d_bit < cl);
wire [4:0] t_idx = tdm ? rel[4:0] : d_bit[4:0];
wire t_val = held[~t_idx];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dout_reg <= 1'b0;
        dout_oe_reg <= 1'b0;
    end else if (!en) begin
        dout_reg <= 1'b0;
        dout_oe_reg <= 1'b0;
    end else if (d_go) begin
        // launched on the active edge that also captures input
        if (t_word & in_range) begin
            dout_reg <= t_val;
            dout_oe_reg <= 1'b1;
        end else if (t_pad & in_range) begin
            dout_reg <= 1'b0;
            dout_oe_reg <= ~hiz;
        end else begin
            dout_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
        end
    end else if (act) begin
        dout_reg <= 1'b0;
        dout_oe_reg <= 1'b0;
    end
end

assign dout = dout_reg;
assign dout_oe = dout_oe_reg;
assign spk_data = spk_data_reg;
assign spk_valid = spk_valid_reg;

// ----------------------------------------
// status and submodules
// ----------------------------------------
assign status = {13'h0000, run_reg, slots, chans, rep_ratio};

pcm_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl(ctrl),
    .clock(clock),
    .route(route),
    .status(status),
    .rxdata(spk_data_reg)
);

// sense sample held for the rate ratio of frames
pcm_sense_repeat u_rep (
    .pclk(pclk),
    .presetn(presetn),
    .frame(fstart),
    .sr_code(clock[`CLK_SR]),
    .sense_code(clock[`CLK_SENSE]),
    .sense_data(sense_data),
    .held(held),
    .take(sense_take),
    .ratio(rep_ratio)
);

endmodule

// File: verif/pcm_target_if_monitor.sv
`timescale 1ns/1ps
module pcm_target_if_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pcm pins
    input wire logic bclk,
    input wire logic lrclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    // paths
    input wire logic [31:0] spk_data,
    input wire logic spk_valid,
    input wire logic [31:0] sense_data,
    input wire logic sense_take
);
    logic bclk_q_reg;
    logic [3:0] quiet_reg;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // cycles since the bit clock last moved
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_q_reg <= 1'b0;
            quiet_reg <= 4'h0;
        end else begin
            bclk_q_reg <= bclk;
            if (bclk != bclk_q_reg) begin
                quiet_reg <= 4'h0;
            end else if (quiet_reg != 4'hf) begin
                quiet_reg <= quiet_reg + 4'h1;
            end
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_ready_after_setup;
        s_setup |=> s_access;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");
    property p_ready_needs_setup;
        pready |-> $past(psel) && !$past(penable);
    endproperty
    a_ready_needs_setup: assert property (p_ready_needs_setup) else $error("stray ready");
    property p_err_in_access;
        pslverr |-> s_access;
    endproperty
    a_err_in_access: assert property (p_err_in_access) else $error("stray slverr");
    property p_valid_pulse;
        spk_valid |=> !spk_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_take_pulse;
        sense_take |=> !sense_take;
    endproperty
    a_take_pulse: assert property (p_take_pulse) else $error("take too long");
    property p_data_with_valid;
        !$stable(spk_data) |-> ##[0:1] spk_valid;
    endproperty
    a_data_with_valid: assert property (p_data_with_valid) else $error("silent update");
    property p_valid_on_edge;
        spk_valid |-> quiet_reg < 4'h6;
    endproperty
    a_valid_on_edge: assert property (p_valid_on_edge) else $error("valid off edge");
    property p_dout_on_edge;
        dout_oe && !$stable(dout) |-> quiet_reg < 4'h6;
    endproperty
    a_dout_on_edge: assert property (p_dout_on_edge) else $error("dout off edge");
endmodule

bind pcm_target_if pcm_target_if_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bclk(bclk), .lrclk(lrclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .spk_data(spk_data), .spk_valid(spk_valid), .sense_data(sense_data),
    .sense_take(sense_take)
);

// File: verif/pcm_host_model.sv
`timescale 1ns/1ps
module pcm_host_model (
    // system clock
    input wire logic pclk,
    // host pins
    output logic bclk,
    output logic lrclk,
    output logic din,
    // device output
    input wire logic dout,
    input wire logic dout_oe
);
    logic cap_d [0:511];
    logic cap_oe [0:511];
    initial begin
        bclk = 1'b0;
        lrclk = 1'b1;
        din = 1'b0;
    end
    task automatic half(input logic lvl);
        bclk <= lvl;
        repeat (3) @(posedge pclk);
    endtask
    // one frame, bit clock still outside it
    task automatic frame(input logic [2:0] fmt, input logic act, input logic pol,
        input int ratio, input int cl, input logic [31:0] base);
        int d;
        int q;
        int c;
        logic tdm;
        logic [31:0] w;
        tdm = fmt >= 3'h2;
        d = (fmt == 3'h0) ? 1 : (tdm ? int'(fmt) - 2 : 0);
        lrclk <= tdm ? pol : !pol;
        half(!act);
        half(act);
        for (int n = 0; n <= ratio; n++) begin
            if (n > 0) begin
                cap_d[n - 1] = dout;
                cap_oe[n - 1] = dout_oe;
            end
            if (n < ratio) begin
                q = n - d;
                c = q / cl;
                w = base ^ (32'(c) << 28);
                lrclk <= tdm ? (n == 0) ^ pol : (n >= cl) ^ pol;
                din <= (q < 0 || c >= ratio / cl) ? !din : w[31 - q % cl];
                half(!act);
                half(act);
            end
        end
        half(!act);
        din <= !din;
    endtask
endmodule

// File: verif/pcm_slave_clock_format_tb_top.sv
`timescale 1ns/1ps
`include "pcm_defs.vh"
module pcm_slave_clock_format_tb_top;
    localparam logic [31:0] SENSE = 32'hc35a_96e1;
    localparam logic [31:0] BASE = 32'ha5c3_1e87;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] sense_data;
    wire [31:0] prdata;
    wire [31:0] spk_data;
    wire pready, pslverr, bclk, lrclk, din, dout, dout_oe, spk_valid, sense_take;
    int n_errors = 0;
    int checked = 0;
    int n_take = 0;
    int n_valid = 0;
    int cyc = 0;
    logic [31:0] r;
    logic e;

    pcm_target_if dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bclk(bclk), .lrclk(lrclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .spk_data(spk_data), .spk_valid(spk_valid), .sense_data(sense_data),
        .sense_take(sense_take)
    );
    pcm_host_model host (
        .pclk(pclk), .bclk(bclk), .lrclk(lrclk), .din(din), .dout(dout), .dout_oe(dout_oe)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (sense_take === 1'b1) n_take++;
        if (spk_valid === 1'b1) n_valid++;
        if (cyc == 60000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(`OFS_CTRL, 32'h0000_0080);
        rd(`OFS_CLOCK, 32'h0000_4033);
        rd(`OFS_STATUS, 32'h0000_2041);
        apb(1'b1, `OFS_CTRL, 32'hffff_fffe);
        rd(`OFS_CTRL, 32'h0000_07fe);
        rd(8'h14, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
    endtask
    task automatic run(input logic [2:0] fmt, input logic act, input logic pol,
        input logic hiz, input int ratio, input logic [1:0] clc, input logic [1:0] wsc,
        input logic [3:0] ch, input logic [6:0] slot);
        int clb;
        int wsb;
        int q;
        int v;
        logic eoe;
        logic [31:0] x;
        clb = 16 + 8 * clc;
        wsb = 16 + 8 * wsc;
        apb(1'b1, `OFS_CLOCK, {14'h0, 10'(ratio), 8'h33});
        apb(1'b1, `OFS_ROUTE, {21'h0, slot, ch});
        apb(1'b1, `OFS_CTRL, {21'h0, hiz, pol, act, clc, wsc, fmt, 1'b1});
        host.frame(fmt, act, pol, ratio, clb, BASE);
        v = n_valid;
        host.frame(fmt, act, pol, ratio, clb, BASE);
        chk(32'(n_valid - v), 32'h0000_0001);
        x = (BASE ^ {ch, 28'h0}) & ~(32'hffff_ffff >> wsb);
        chk(spk_data, x);
        rd(`OFS_RXDATA, x);
        if (fmt == `FMT_LJ || fmt == `FMT_TDM0) begin
            for (int n = 0; n < ratio; n++) begin
                q = (fmt == `FMT_LJ) ? n % clb : n - 8 * slot;
                eoe = q >= 0 && q < clb && (q < wsb || !hiz);
                chk({30'h0, host.cap_oe[n], host.cap_d[n] & eoe},
                    {30'h0, eoe, eoe && q < wsb && SENSE[31 - q]});
            end
        end
    endtask
    task automatic t_sense();
        int k;
        int f1;
        int f2;
        apb(1'b1, `OFS_CLOCK, 32'h0000_20b0);
        apb(1'b1, `OFS_CTRL, 32'h0000_0003);
        f1 = -1;
        f2 = -1;
        for (int i = 0; i < 50; i++) begin
            k = n_take;
            host.frame(`FMT_LJ, 1'b0, 1'b0, 32, 16, BASE);
            if (n_take != k && f1 >= 0 && f2 < 0) f2 = i;
            if (n_take != k && f1 < 0) f1 = i;
            if (i == 1) sense_data <= ~SENSE;
            if (i == 23 || i == 24) begin
                chk({31'h0, host.cap_d[0]}, {31'h0, SENSE[31] ^ (i == 24)});
            end
        end
        chk(32'(f2 - f1), 32'h0000_0018);
        rd(`OFS_STATUS, 32'h0004_1058);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sense_data = SENSE;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        run(`FMT_LJ, 1'b0, 1'b0, 1'b0, 64, `LEN_32, `LEN_16, 4'h0, 7'h0);
        run(`FMT_LJ, 1'b1, 1'b1, 1'b1, 64, `LEN_32, `LEN_24, 4'h1, 7'h0);
        run(`FMT_I2S, 1'b0, 1'b0, 1'b0, 48, `LEN_24, `LEN_24, 4'h0, 7'h0);
        run(`FMT_TDM0, 1'b0, 1'b0, 1'b1, 64, `LEN_16, `LEN_16, 4'h3, 7'h2);
        run(`FMT_TDM1, 1'b1, 1'b0, 1'b0, 128, `LEN_32, `LEN_32, 4'h2, 7'h0);
        run(`FMT_TDM2, 1'b0, 1'b1, 1'b0, 96, `LEN_24, `LEN_16, 4'h3, 7'h0);
        t_sense();
        results();
    end
endmodule
